// file: irq_enable_core.sv
/*
  Execution logic for the interrupt enable/disable instructions with an AHB-Lite
  slave giving software the status register, an instruction issue port and counters.
  Assumes a single master, word transfers only, and clk_in at 125 MHz.
*/
`timescale 1ns/1ps
module irq_enable_core (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic irq_request_in,
  output logic irq_accept_out,
  output logic irq_enable_out,
  output logic [15:0] status_register_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [irq_enable_pkg::SR_W-1:0] execute(
    input logic [irq_enable_pkg::SR_W-1:0] sr,
    input irq_enable_pkg::instr_t ins
  );
    logic [irq_enable_pkg::SR_W-1:0] result;
    result = sr;
    unique case (ins.op)
      irq_enable_pkg::OP_DISABLE_INTERRUPTS: begin
        // Only the enable bit is in the mask, so flags and mode bits survive
        result = (~irq_enable_pkg::GIE_CONST) & sr; // RL1 RL2 RL3 RL4
      end
      irq_enable_pkg::OP_ENABLE_INTERRUPTS: begin
        result = irq_enable_pkg::GIE_CONST | sr; // RL5 RL6 RL8
      end
      irq_enable_pkg::OP_BIT_CLEAR: begin
        result = (~ins.operand) & sr;
      end
      irq_enable_pkg::OP_BIT_SET: begin
        result = ins.operand | sr;
      end
      irq_enable_pkg::OP_NO_OPERATION: begin
        result = sr;
      end
      default: begin
        // Undefined op codes behave as no operation
        result = sr;
      end
    endcase
    return result;
  endfunction

  function automatic logic is_enable_op(input irq_enable_pkg::instr_t ins);
    return ins.op == irq_enable_pkg::OP_ENABLE_INTERRUPTS;
  endfunction

  // ****************************************
  // State
  // ****************************************
  irq_enable_pkg::addr_phase_t data_phase;
  irq_enable_pkg::addr_phase_t next_data_phase;
  logic [irq_enable_pkg::SR_W-1:0] status_register;
  logic [irq_enable_pkg::SR_W-1:0] next_status_register;
  logic enable_shadow;
  logic next_enable_shadow;
  logic irq_accept;
  logic next_irq_accept;
  logic [31:0] last_instr;
  logic [31:0] next_last_instr;
  logic [31:0] exec_count;
  logic [31:0] next_exec_count;
  logic [31:0] accept_count;
  logic [31:0] next_accept_count;
  logic [31:0] read_data;
  logic [31:0] next_read_data;

  logic addr_take;
  logic data_write;
  logic issue;
  irq_enable_pkg::instr_t issued;
  logic [irq_enable_pkg::SR_W-1:0] executed_sr;
  logic [31:0] irq_state_word;

  // ****************************************
  // Bus slave
  // ****************************************
  // A frozen clock enable stretches the data phase so no transfer is lost
  assign hreadyout_out = ce_in;
  assign hresp_out = irq_enable_pkg::HRESP_OKAY;
  assign hrdata_out = read_data;

  assign addr_take = hsel_in && htrans_in[1] && hready_in &&
                     (hsize_in == irq_enable_pkg::HSIZE_WORD);
  assign data_write = data_phase.valid && data_phase.write;
  assign issue = data_write && (data_phase.addr == irq_enable_pkg::INSTR_OFS);
  assign issued = irq_enable_pkg::instr_t'(hwdata_in);
  assign executed_sr = execute(status_register, issued);

  always_comb begin
    irq_state_word = irq_enable_pkg::WORD_ZERO;
    irq_state_word[irq_enable_pkg::IRQ_STATE_GIE] = status_register[irq_enable_pkg::GIE_POS];
    irq_state_word[irq_enable_pkg::IRQ_STATE_SHADOW] = enable_shadow;
    irq_state_word[irq_enable_pkg::IRQ_STATE_REQUEST] = irq_request_in;
    irq_state_word[irq_enable_pkg::IRQ_STATE_ALLOWED] = irq_enable_out;
  end

  always_comb begin
    next_data_phase = data_phase;
    next_read_data = read_data;
    if (hready_in) begin
      next_data_phase.valid = addr_take;
      next_data_phase.write = hwrite_in;
      next_data_phase.addr = haddr_in[irq_enable_pkg::ADDR_W-1:0];
      // Read data is prepared in the address phase so it stands in a zero-wait data phase
      next_read_data = irq_enable_pkg::WORD_ZERO;
      if (addr_take && !hwrite_in) begin
        unique case (haddr_in[irq_enable_pkg::ADDR_W-1:0])
          irq_enable_pkg::STATUS_OFS: begin
            next_read_data = {16'h0000, next_status_register};
          end
          irq_enable_pkg::INSTR_OFS: begin
            next_read_data = next_last_instr;
          end
          irq_enable_pkg::EXEC_COUNT_OFS: begin
            next_read_data = next_exec_count;
          end
          irq_enable_pkg::IRQ_STATE_OFS: begin
            next_read_data = irq_state_word;
          end
          irq_enable_pkg::ACCEPT_COUNT_OFS: begin
            next_read_data = next_accept_count;
          end
          default: begin
            next_read_data = irq_enable_pkg::WORD_ZERO;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Execution and acceptance
  // ****************************************
  always_comb begin
    next_status_register = status_register;
    next_enable_shadow = enable_shadow;
    next_irq_accept = 1'b0;
    next_last_instr = last_instr;
    next_exec_count = exec_count;
    next_accept_count = accept_count;
    if (data_write && (data_phase.addr == irq_enable_pkg::STATUS_OFS)) begin
      next_status_register = hwdata_in[irq_enable_pkg::SR_W-1:0];
    end
    if (issue) begin
      next_status_register = executed_sr;
      next_last_instr = hwdata_in;
      next_exec_count = exec_count + irq_enable_pkg::COUNT_ONE;
      // An enable opens a one-instruction window in which nothing is accepted
      next_enable_shadow = is_enable_op(issued); // RL9
      // Acceptance is judged at instruction boundaries on the new enable bit
      next_irq_accept = irq_request_in && executed_sr[irq_enable_pkg::GIE_POS] &&
                        !is_enable_op(issued); // RL1 RL9
      if (next_irq_accept) begin
        next_accept_count = accept_count + irq_enable_pkg::COUNT_ONE;
      end
    end
  end

  assign irq_accept_out = irq_accept;
  assign irq_enable_out = status_register[irq_enable_pkg::GIE_POS] && !enable_shadow; // RL9
  assign status_register_out = status_register;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      data_phase <= '0;
      read_data <= irq_enable_pkg::WORD_ZERO;
      status_register <= irq_enable_pkg::SR_RESET;
      enable_shadow <= 1'b0;
      irq_accept <= 1'b0;
      last_instr <= irq_enable_pkg::WORD_ZERO;
      exec_count <= irq_enable_pkg::WORD_ZERO;
      accept_count <= irq_enable_pkg::WORD_ZERO;
    end else if (ce_in) begin
      data_phase <= next_data_phase;
      read_data <= next_read_data;
      status_register <= next_status_register;
      enable_shadow <= next_enable_shadow;
      irq_accept <= next_irq_accept;
      last_instr <= next_last_instr;
      exec_count <= next_exec_count;
      accept_count <= next_accept_count;
    end
  end

endmodule

// file: irq_enable_pkg.sv
/*
  Constants, types and register map shared by the interrupt-enable execution block.
  Assumes a single AHB-Lite master and one 125 MHz core clock.
*/
// Notes on behaviour
// [RL1] Disable op clears enable bit, blocks acceptance
// [RL2] Disable is AND with inverted constant eight
// [RL3] Disable keeps negative, zero, carry, overflow flags
// [RL4] Disable keeps oscillator-off and core-halt bits
// [RL5] Enable op sets enable bit, permits acceptance
// [RL6] Enable is OR of constant eight
// [RL7] Software places disable one instruction early
// [RL8] Enable touches only the enable bit
// [RL9] Instruction after enable runs before acceptance
package irq_enable_pkg;

  // ****************************************
  // Status register layout
  // ****************************************
  localparam int SR_W = 16;
  localparam logic [SR_W-1:0] GIE_CONST = 16'h0008;
  localparam logic [SR_W-1:0] SR_RESET = 16'h0000;
  localparam int CARRY_POS = 0;
  localparam int ZERO_POS = 1;
  localparam int NEG_POS = 2;
  localparam int GIE_POS = 3;
  localparam int CORE_HALT_POS = 4;
  localparam int OSC_OFF_POS = 5;
  localparam int OVERFLOW_POS = 8;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] INSTR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] EXEC_COUNT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STATE_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] ACCEPT_COUNT_OFS = 8'h10;
  localparam int IRQ_STATE_GIE = 0;
  localparam int IRQ_STATE_SHADOW = 1;
  localparam int IRQ_STATE_REQUEST = 2;
  localparam int IRQ_STATE_ALLOWED = 3;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

  // ****************************************
  // Instruction word
  // ****************************************
  typedef enum logic [2:0] {
    OP_NO_OPERATION = 3'b000,
    OP_DISABLE_INTERRUPTS = 3'b001,
    OP_ENABLE_INTERRUPTS = 3'b010,
    OP_BIT_CLEAR = 3'b011,
    OP_BIT_SET = 3'b100
  } op_t;

  typedef struct packed {
    logic [SR_W-1:0] operand;
    logic [12:0] reserved;
    logic [2:0] op;
  } instr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } addr_phase_t;

endpackage

// file: irq_enable_core_sva.sv
/* Port assertions for the interrupt enable core.
   Assumes hready_in is the core's own hreadyout_out. */
`timescale 1ns/1ps
module irq_enable_core_sva (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic irq_accept_out,
  input wire logic irq_enable_out,
  input wire logic [15:0] status_register_out
);
  logic wr_q;
  logic next_wr_q;
  // Instruction write pending its data phase
  always_comb begin
    next_wr_q = wr_q;
    if (hready_in) begin
      next_wr_q = hsel_in && htrans_in[1] && hwrite_in && ce_in && hsize_in == 3'h2
        && haddr_in[7:0] == 8'h04;
    end
  end
  always_ff @(posedge clk_in) begin
    wr_q <= nrst_in ? next_wr_q : 1'b0;
  end
  sequence dis_s; wr_q && hready_in && hwdata_in[2:0] == 3'h1; endsequence
  sequence en_s; wr_q && hready_in && hwdata_in[2:0] == 3'h2; endsequence
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_dis_gie_off: assert property (dis_s |=> !status_register_out[3] && !irq_accept_out)
    else $error("enable bit or accept after disable");
  a_dis_mask_and: assert property (dis_s |=> status_register_out == ($past(status_register_out) & 16'hFFF7))
    else $error("disable result not masked status");
  a_dis_flags_kept: assert property (dis_s |=> (status_register_out & 16'h0107) == ($past(status_register_out) & 16'h0107))
    else $error("flags changed by disable");
  a_dis_modes_kept: assert property (dis_s |=> $stable(status_register_out[5:4]))
    else $error("mode bits changed by disable");
  a_en_gie_on: assert property (en_s |=> status_register_out[3])
    else $error("enable bit not set");
  a_en_or_eight: assert property (en_s |=> status_register_out == ($past(status_register_out) | 16'h0008))
    else $error("enable result not status or eight");
  a_en_only_gie: assert property (en_s |=> ((status_register_out ^ $past(status_register_out)) & 16'hFFF7) == 16'h0000)
    else $error("enable changed other bits");
  a_en_next_first: assert property (en_s |=> !irq_accept_out && !irq_enable_out)
    else $error("accept before next instruction");
endmodule
bind irq_enable_core irq_enable_core_sva u_sva (.clk_in(clk_in), .nrst_in(nrst_in),
  .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .irq_accept_out(irq_accept_out), .irq_enable_out(irq_enable_out),
  .status_register_out(status_register_out));

// file: testbench.sv
/* Self-checking bench for the interrupt enable core.
   Assumes a single AHB-Lite master; hready is the core's hreadyout. */
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic irq_req = 1'b0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic accept;
  logic irq_en;
  logic [15:0] status;
  logic [31:0] rd;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  irq_enable_core DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .irq_request_in(irq_req), .irq_accept_out(accept),
    .irq_enable_out(irq_en), .status_register_out(status));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready and read data are sampled at the rising edge that ends each phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_in);
    while (!hready) begin
      @(posedge clk_in);
    end
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (!hready) begin
      @(posedge clk_in);
    end
    rd = hrdata;
  endtask
  task automatic run(input logic [2:0] op, input logic [15:0] exp_sr, input logic exp_acc);
    xfer(8'h04, 1'b1, {29'h0000_0000, op});
    @(negedge clk_in);
    check({16'h0000, status}, {16'h0000, exp_sr});
    check({31'h0000_0000, accept}, {31'h0000_0000, exp_acc});
    @(posedge clk_in);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    xfer(8'h00, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    xfer(8'h20, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_disable();
    xfer(8'h00, 1'b1, 32'h0000_013F);
    irq_req <= 1'b1;
    run(3'h1, 16'h0137, 1'b0);
    run(3'h0, 16'h0137, 1'b0);
    check({31'h0000_0000, irq_en}, 32'h0000_0000);
    $display("test disable done");
  endtask
  task automatic t_enable();
    xfer(8'h00, 1'b1, 32'h0000_0130);
    run(3'h2, 16'h0138, 1'b0);
    check({31'h0000_0000, irq_en}, 32'h0000_0000);
    run(3'h0, 16'h0138, 1'b1);
    check({31'h0000_0000, irq_en}, 32'h0000_0001);
    run(3'h1, 16'h0130, 1'b0);
    xfer(8'h10, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    irq_req <= 1'b0;
    $display("test enable done");
  endtask
  // A low clock enable must stall the bus and freeze the instruction
  task automatic t_stall();
    ce_in <= 1'b0;
    fork
      xfer(8'h04, 1'b1, 32'h0000_0002);
      begin
        @(negedge clk_in);
        check({31'h0000_0000, hready}, 32'h0000_0000);
        check({16'h0000, status}, 32'h0000_0130);
        repeat (3) @(posedge clk_in);
        ce_in <= 1'b1;
      end
    join
    @(negedge clk_in);
    check({16'h0000, status}, 32'h0000_0138);
    check({31'h0000_0000, hready}, 32'h0000_0001);
    @(posedge clk_in);
    xfer(8'h0C, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    $display("test stall done");
  endtask
  task automatic t_ops();
    xfer(8'h00, 1'b1, 32'h0000_0000);
    xfer(8'h04, 1'b1, 32'h0021_0004);
    xfer(8'h00, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0021);
    xfer(8'h04, 1'b1, 32'h0001_0003);
    xfer(8'h00, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    xfer(8'h04, 1'b0, 32'h0000_0000);
    check(rd, 32'h0001_0003);
    xfer(8'h08, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0008);
    $display("test ops done");
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_disable();
    t_enable();
    t_stall();
    t_ops();
    complete_run();
  end
endmodule
